/* File: sps_regs.svh */
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// register offsets (byte addresses, one aligned word each)
`define SPS_CMD_OFS      8'h00
`define SPS_ADDR_OFS     8'h04
`define SPS_RETRY_OFS    8'h08
`define SPS_STATUS_OFS   8'h0c

// status field positions
`define SPS_ST_RDY_BIT   0
`define SPS_ST_ARRAY_READY_FLAG_BIT  1
`define SPS_ST_SUSP_BIT  2
`define SPS_ST_QUEUE_BIT 3
`define SPS_ST_PEND_LSB  8

// reset values
`define SPS_RETRY_RST    4'h0

// command opcodes
`define SPS_OP_READ0     8'h00
`define SPS_OP_CONFIRM   8'h10
`define SPS_OP_QUEUE     8'h11
`define SPS_OP_RESUME    8'h13
`define SPS_OP_READ      8'h30
`define SPS_OP_READ_MP   8'h32
`define SPS_OP_STAT      8'h70
`define SPS_OP_STAT_ENH  8'h78
`define SPS_OP_SETUP     8'h80
`define SPS_OP_SUSPEND   8'h84
`define SPS_OP_CHG_COL   8'h85
`define SPS_OP_RST_FF    8'hff
`define SPS_OP_RST_FC    8'hfc
`define SPS_OP_RST_FA    8'hfa

// timing: times in ns, counts in cycles of the 40 MHz clock
`define SPS_CLK_MHZ      40
`define SPS_CYC_UP(ns)   ((((ns) * `SPS_CLK_MHZ) + 999) / 1000)
`define SPS_T_PBSY_NS    10000
`define SPS_T_PROG_NS    750000
`define SPS_T_DBSY_NS    1000
`define SPS_T_PSPD_NS    10000
`define SPS_T_READ_NS    59000
`define SPS_PBSY_CYC     `SPS_CYC_UP(`SPS_T_PBSY_NS)
`define SPS_PROG_CYC     `SPS_CYC_UP(`SPS_T_PROG_NS)
`define SPS_DBSY_CYC     `SPS_CYC_UP(`SPS_T_DBSY_NS)
`define SPS_PSPD_CYC     `SPS_CYC_UP(`SPS_T_PSPD_NS)
`define SPS_READ_CYC     `SPS_CYC_UP(`SPS_T_READ_NS)

`endif

/* File: sps_pkg.sv */
package sps_pkg;

    // sequencer states, gray along idle-load-busy-suspended
    typedef enum logic [1:0] {
        SPS_IDLE = 2'b00,
        SPS_LOAD = 2'b01,
        SPS_BUSY = 2'b11,
        SPS_SUSP = 2'b10
    } sps_state_type;

    // what the current busy period is doing
    typedef enum logic [2:0] {
        SPS_BK_XFER = 3'h0,
        SPS_BK_PROG = 3'h1,
        SPS_BK_DQ   = 3'h2,
        SPS_BK_READ = 3'h3,
        SPS_BK_SPD  = 3'h4
    } sps_busy_type;

    // page address as held in the address register
    typedef struct packed {
        logic       unshared;
        logic       upper;
        logic [1:0] plane;
    } sps_page_type;

endpackage

/* File: sps_seq.sv */
// Design decisions made here: the plain strobed port and the address map.
`include "sps_regs.svh"
// Function
// - retry setting applies to every later array read until rewritten
// - lower confirm drops both ready flags for the short transfer time
// - upper confirm starts programming, flags low for full program time
// - reset before program time aborts; host restarts whole sequence
// - no pair check; upper address decides the programmed pair
// - second lower load to same plane overwrites; upper still needed
// - suspend and resume accepted during single-pass programming
// - unshared page programs with one load and confirm
// - setup accepted only when ready; unqueued confirm programs one page
// - setup without a preceding queue confirm clears all cache registers
// - data input after setup; column changes allowed during input
// - queue confirm makes the die busy for the dummy-busy time
module sps_seq #(
    parameter int unsigned P_PROG_CYC = `SPS_PROG_CYC,
    parameter int unsigned P_READ_CYC = `SPS_READ_CYC,
    parameter int unsigned P_PBSY_CYC = `SPS_PBSY_CYC,
    parameter int unsigned P_DBSY_CYC = `SPS_DBSY_CYC,
    parameter int unsigned P_PSPD_CYC = `SPS_PSPD_CYC
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic [7:0]          i_addr,
    input  wire logic [31:0]         i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic [31:0]              o_rdata,
    output logic                     o_rdy,
    output logic                     o_array_ready_flag,
    output logic                     o_prog_start,
    output logic                     o_cache_clear,
    output logic [3:0]               o_read_setting,
    output sps_pkg::sps_page_type    o_prog_page
);
    import sps_pkg::*;
    localparam int CW = 20;
    sps_state_type st_r, st_nxt;
    sps_busy_type  kind_r, kind_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt, rem_r;
    sps_page_type  page_r;
    logic [3:0]    retry_r;
    logic [3:0]    pend_r;
    logic          queued_r;

    ////////////////////////////////////////////////////////////////////////
    // command decode
    logic       cmd_wr;
    logic [7:0] op;
    logic       is_reset, setup, lower_conf, final_conf, queue_conf;
    logic       read_go, susp_go, resume_go;

    assign cmd_wr     = i_wr && (i_addr == `SPS_CMD_OFS);
    assign op         = i_wdata[7:0];
    assign is_reset   = cmd_wr && (op == `SPS_OP_RST_FF || op == `SPS_OP_RST_FC
                                   || op == `SPS_OP_RST_FA);
    // setup only decodes when idle, so a busy die ignores it
    assign setup      = cmd_wr && (st_r == SPS_IDLE) && (op == `SPS_OP_SETUP);
    assign queue_conf = cmd_wr && (st_r == SPS_LOAD) && (op == `SPS_OP_QUEUE);
    assign lower_conf = cmd_wr && (st_r == SPS_LOAD) && !page_r.upper && !page_r.unshared
                        && (op == `SPS_OP_CONFIRM || op == `SPS_OP_QUEUE);
    assign final_conf = cmd_wr && (st_r == SPS_LOAD) && (op == `SPS_OP_CONFIRM)
                        && (page_r.upper || page_r.unshared);
    assign read_go    = cmd_wr && (st_r == SPS_IDLE)
                        && (op == `SPS_OP_READ || op == `SPS_OP_READ_MP);
    assign susp_go    = cmd_wr && (st_r == SPS_BUSY) && (kind_r == SPS_BK_PROG)
                        && (op == `SPS_OP_SUSPEND);
    assign resume_go  = cmd_wr && (st_r == SPS_SUSP) && (op == `SPS_OP_RESUME);

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state; busy periods count down from n-1 to zero, a resumed one from the saved count
    always_comb begin
        st_nxt   = st_r;
        kind_nxt = kind_r;
        cnt_nxt  = cnt_r;
        if (is_reset) begin
            st_nxt  = SPS_IDLE;
            cnt_nxt = '0;
        end else begin
            case (st_r)
                SPS_IDLE: begin
                    if (setup) begin
                        st_nxt = SPS_LOAD;
                    end else if (read_go) begin
                        st_nxt = SPS_BUSY;
                        if (op == `SPS_OP_READ) begin
                            kind_nxt = SPS_BK_READ;
                            cnt_nxt  = CW'(P_READ_CYC - 1);
                        end else begin
                            kind_nxt = SPS_BK_DQ;
                            cnt_nxt  = CW'(P_DBSY_CYC - 1);
                        end
                    end
                end
                SPS_LOAD: begin
                    // column and row changes keep the load open
                    if (queue_conf) begin
                        st_nxt   = SPS_BUSY;
                        kind_nxt = SPS_BK_DQ;
                        cnt_nxt  = CW'(P_DBSY_CYC - 1);
                    end else if (final_conf) begin
                        st_nxt   = SPS_BUSY;
                        kind_nxt = SPS_BK_PROG;
                        cnt_nxt  = CW'(P_PROG_CYC - 1);
                    end else if (lower_conf) begin
                        st_nxt   = SPS_BUSY;
                        kind_nxt = SPS_BK_XFER;
                        cnt_nxt  = CW'(P_PBSY_CYC - 1);
                    end
                end
                SPS_BUSY: begin
                    if (susp_go) begin
                        kind_nxt = SPS_BK_SPD;
                        cnt_nxt  = CW'(P_PSPD_CYC - 1);
                    end else if (cnt_r == '0) begin
                        st_nxt = (kind_r == SPS_BK_SPD) ? SPS_SUSP : SPS_IDLE;
                    end else begin
                        cnt_nxt = cnt_r - CW'(1);
                    end
                end
                SPS_SUSP: begin
                    if (resume_go) begin
                        st_nxt   = SPS_BUSY;
                        kind_nxt = SPS_BK_PROG;
                        cnt_nxt  = rem_r;
                    end
                end
                default: st_nxt = SPS_IDLE;
            endcase
        end
    end

    // sequencer state and ready flags, both flags low through any busy period
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r   <= SPS_IDLE;
            kind_r <= SPS_BK_XFER;
            cnt_r  <= '0;
            o_rdy  <= 1'b1;
            o_array_ready_flag <= 1'b1;
        end else begin
            st_r   <= st_nxt;
            kind_r <= kind_nxt;
            cnt_r  <= cnt_nxt;
            o_rdy  <= (st_nxt != SPS_BUSY);
            o_array_ready_flag <= (st_nxt != SPS_BUSY);
        end
    end

    // remaining program time saved at suspend so resume finishes the job
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rem_r <= '0;
        end else if (susp_go) begin
            rem_r <= cnt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending lower pages and multi-plane queue
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_r   <= '0;
            queued_r <= 1'b0;
        end else if (is_reset) begin
            pend_r   <= '0;
            queued_r <= 1'b0;
        end else begin
            if (lower_conf) begin
                pend_r[page_r.plane] <= 1'b1;
            end else if (final_conf) begin
                pend_r <= '0;
            end
            if (queue_conf) begin
                queued_r <= 1'b1;
            end else if (cmd_wr && st_r == SPS_LOAD && op == `SPS_OP_CONFIRM) begin
                queued_r <= 1'b0;
            end
        end
    end

    // program launch and cache clear pulses; the programmed pair is the upper one
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prog_start  <= 1'b0;
            o_cache_clear <= 1'b0;
            o_prog_page   <= '0;
        end else begin
            o_prog_start  <= final_conf;
            o_cache_clear <= setup && !queued_r;
            if (final_conf) begin
                o_prog_page <= page_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes: page address and retry setting
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_r  <= '0;
            retry_r <= `SPS_RETRY_RST;
        end else if (i_wr) begin
            if (i_addr == `SPS_ADDR_OFS) begin
                page_r <= i_wdata[3:0];
            end
            if (i_addr == `SPS_RETRY_OFS) begin
                retry_r <= i_wdata[3:0];
            end
        end
    end

    // the retry option is latched at each array read so mid-read writes do not tear it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_read_setting <= `SPS_RETRY_RST;
        end else if (read_go) begin
            o_read_setting <= retry_r;
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= '0;
            case (i_addr)
                `SPS_ADDR_OFS:  o_rdata[3:0] <= page_r;
                `SPS_RETRY_OFS: o_rdata[3:0] <= retry_r;
                `SPS_STATUS_OFS: begin
                    o_rdata[`SPS_ST_RDY_BIT]   <= o_rdy;
                    o_rdata[`SPS_ST_ARRAY_READY_FLAG_BIT]  <= o_array_ready_flag;
                    o_rdata[`SPS_ST_SUSP_BIT]  <= (st_r == SPS_SUSP);
                    o_rdata[`SPS_ST_QUEUE_BIT] <= queued_r;
                    o_rdata[`SPS_ST_PEND_LSB +: 4] <= pend_r;
                end
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_busy_flags;
        !o_rdy && !o_array_ready_flag;
    endsequence
    sequence s_busy_two;
        s_busy_flags ##1 s_busy_flags;
    endsequence

    retry_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        read_go |=> (o_read_setting == $past(retry_r))) else $error("retry setting not applied");
    lower_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (lower_conf && op == `SPS_OP_CONFIRM && !is_reset) |=> s_busy_two
        and ##1 (kind_r == SPS_BK_XFER))
        else $error("lower confirm did not start the transfer busy");
    prog_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        final_conf |=> (o_prog_start && kind_r == SPS_BK_PROG
                        && cnt_r == CW'(P_PROG_CYC - 1)) and s_busy_flags)
        else $error("upper confirm did not start programming");
    reset_abort_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_reset |=> (st_r == SPS_IDLE && pend_r == '0 && !queued_r && o_rdy))
        else $error("reset did not abort the sequence");
    pend_mark_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (lower_conf && !is_reset) |=> pend_r[$past(page_r.plane)])
        else $error("pending flag not set by lower confirm");
    susp_accept_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (susp_go && !is_reset) |=> (kind_r == SPS_BK_SPD && rem_r == $past(cnt_r)))
        else $error("suspend not taken during programming");
    setup_ready_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (cmd_wr && op == `SPS_OP_SETUP && st_r == SPS_BUSY) |=> (st_r != SPS_LOAD))
        else $error("setup accepted while busy");
    cache_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (setup && !queued_r) |=> o_cache_clear ##1 !o_cache_clear)
        else $error("cache clear pulse missing");
    queue_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (queue_conf && !is_reset) |=> (kind_r == SPS_BK_DQ) and s_busy_flags)
        else $error("queue confirm did not start dummy busy");
    pair_page_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        final_conf |=> (o_prog_page == $past(page_r))) else $error("wrong programmed pair");
endmodule

/* File: sps_host.sv */
module sps_host (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rdy,
    output logic [7:0]       o_addr,
    output logic [31:0]      o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle from time zero
    initial begin
        o_addr  = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle write; strobe dropped at the edge that takes it
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask

    // polls ready and counts busy cycles; bounded so a stuck die cannot hang us
    task automatic wait_rdy(input int lim, output int n);
        n = 0;
        while (n < lim) begin
            @(posedge i_clk);
            #1;
            if (i_rdy) break;
            n++;
        end
    endtask
endmodule

/* File: sps_seq_bench.sv */
`include "sps_regs.svh"
module sps_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;

    localparam int PROG = 20;
    localparam int READ = 8;
    localparam int PBSY = 6;
    localparam int DBSY = 3;
    localparam int PSPD = 4;

    logic         i_clk = 1'b0;
    logic         i_rst_n = 1'b0;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic         wr;
    logic         rd;
    logic [31:0]  rdata;
    logic         rdy;
    logic         array_ready_flag;
    logic         prog_start;
    logic         cache_clear;
    logic [3:0]   read_setting;
    sps_page_type prog_page;
    logic [31:0]  rv;
    int           cnt;
    int           miscompares = 0;
    int           n_compared = 0;

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    sps_seq #(.P_PROG_CYC(PROG), .P_READ_CYC(READ), .P_PBSY_CYC(PBSY),
              .P_DBSY_CYC(DBSY), .P_PSPD_CYC(PSPD)) sps_seq_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rdy(rdy), .o_array_ready_flag(array_ready_flag),
        .o_prog_start(prog_start), .o_cache_clear(cache_clear),
        .o_read_setting(read_setting), .o_prog_page(prog_page));

    // either flag rising ends a busy count, so a flag that lags goes unnoticed
    sps_host sps_host_i (
        .i_clk(i_clk), .i_rdata(rdata), .i_rdy(rdy | array_ready_flag), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [31:0] st(input logic [3:0] p, input logic q, input logic s);
        return {20'h0, p, 4'h0, q, s, 2'b11};
    endfunction

    task automatic cmd(input logic [7:0] op);
        sps_host_i.wr_reg(`SPS_CMD_OFS, {24'h0, op});
    endtask

    task automatic page(input logic [3:0] v);
        sps_host_i.wr_reg(`SPS_ADDR_OFS, {28'h0, v});
    endtask

    task automatic chk_st(input logic [31:0] exp);
        sps_host_i.rd_reg(`SPS_STATUS_OFS, rv);
        check(rv, exp);
    endtask

    // issue a command and count the cycles both flags stay low
    task automatic busy(input logic [7:0] op);
        cmd(op);
        sps_host_i.wait_rdy(PROG + READ + 8, cnt);
        cnt = cnt + 1; // the first low cycle passes before the first poll
    endtask

    task automatic setup(input logic clr);
        cmd(`SPS_OP_SETUP);
        // the clear pulse stands only in the cycle right after the strobe edge
        #1;
        check(cache_clear, clr);
    endtask

    // final confirm: pulse in the first busy cycle, then the full program time
    task automatic confirm_prog();
        cmd(`SPS_OP_CONFIRM);
        #1;
        check(prog_start, 1'b1);
        sps_host_i.wait_rdy(PROG + 4, cnt);
        check(32'(cnt), 32'(PROG - 1));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({rdy, array_ready_flag, prog_start, cache_clear}, 4'b1100);
        chk_st(st(4'h0, 1'b0, 1'b0));
        sps_host_i.rd_reg(`SPS_RETRY_OFS, rv);
        check(rv, 32'h0);
        sps_host_i.rd_reg(8'h10, rv);
        check(rv, 32'h0);
        $display("test reset done");
    endtask

    // lower, overwrite, then an upper of another plane decides the pair
    task automatic t_pair();
        page(4'h0);
        setup(1'b1);
        busy(`SPS_OP_CONFIRM);
        check(32'(cnt), 32'(PBSY));
        chk_st(st(4'h1, 1'b0, 1'b0));
        busy(`SPS_OP_READ);
        check(32'(cnt), 32'(READ));
        chk_st(st(4'h1, 1'b0, 1'b0));
        setup(1'b1);
        busy(`SPS_OP_CONFIRM);
        check(32'(cnt), 32'(PBSY));
        check(prog_start, 1'b0);
        page(4'h5);
        setup(1'b1);
        cmd(`SPS_OP_CHG_COL);
        confirm_prog();
        check(prog_page, 4'h5);
        chk_st(st(4'h0, 1'b0, 1'b0));
        $display("test pair done");
    endtask

    // every reset opcode aborts during the short transfer busy
    task automatic t_abort();
        logic [7:0] ops [3] = '{`SPS_OP_RST_FF, `SPS_OP_RST_FC, `SPS_OP_RST_FA};
        foreach (ops[i]) begin
            page(4'h0);
            setup(1'b1);
            cmd(`SPS_OP_CONFIRM);
            cmd(ops[i]);
            @(posedge i_clk);
            #1;
            check({rdy, array_ready_flag}, 2'b11);
            chk_st(st(4'h0, 1'b0, 1'b0));
        end
        $display("test abort done");
    endtask

    task automatic t_multi();
        page(4'h0);
        setup(1'b1);
        busy(`SPS_OP_QUEUE);
        check(32'(cnt), 32'(DBSY));
        chk_st(st(4'h1, 1'b1, 1'b0));
        page(4'h1);
        setup(1'b0);
        busy(`SPS_OP_CONFIRM);
        check(32'(cnt), 32'(PBSY));
        chk_st(st(4'h3, 1'b0, 1'b0));
        page(4'h4);
        setup(1'b1);
        busy(`SPS_OP_QUEUE);
        check(32'(cnt), 32'(DBSY));
        page(4'h5);
        setup(1'b0);
        cmd(`SPS_OP_CHG_COL);
        confirm_prog();
        chk_st(st(4'h0, 1'b0, 1'b0));
        $display("test multi-plane done");
    endtask

    // unshared page: one entry programs; then suspend and resume it
    task automatic t_unshared_susp();
        page(4'h8);
        setup(1'b1);
        confirm_prog();
        check(prog_page, 4'h8);
        setup(1'b1);
        cmd(`SPS_OP_CONFIRM);
        repeat (5) @(posedge i_clk);
        cmd(`SPS_OP_SUSPEND);
        sps_host_i.wait_rdy(PROG + PSPD, cnt);
        check(rdy, 1'b1);
        chk_st(st(4'h0, 1'b0, 1'b1));
        cmd(`SPS_OP_RESUME);
        @(posedge i_clk);
        #1;
        check(rdy, 1'b0);
        sps_host_i.wait_rdy(PROG, cnt);
        check(rdy, 1'b1);
        $display("test unshared and suspend done");
    endtask

    task automatic t_retry();
        sps_host_i.wr_reg(`SPS_RETRY_OFS, 32'h5);
        sps_host_i.rd_reg(`SPS_RETRY_OFS, rv);
        check(rv, 32'h5);
        check(read_setting, 4'h0);
        cmd(`SPS_OP_READ);
        setup(1'b0);
        sps_host_i.wait_rdy(READ, cnt);
        check(read_setting, 4'h5);
        cmd(`SPS_OP_CONFIRM);
        @(posedge i_clk);
        #1;
        check({rdy, prog_start}, 2'b10);
        busy(`SPS_OP_READ_MP);
        check(32'(cnt), 32'(DBSY));
        check(read_setting, 4'h5);
        sps_host_i.wr_reg(`SPS_RETRY_OFS, 32'h0);
        busy(`SPS_OP_READ);
        check(32'(cnt), 32'(READ));
        check(read_setting, 4'h0);
        $display("test retry done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: reset held five cycles, then the tests
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1;
        t_reset();
        t_pair();
        t_abort();
        t_multi();
        t_unshared_susp();
        t_retry();
        close_out();
    end

    // watchdog: the tests need well under 2000 cycles
    initial begin
        #(20000 * 25);
        miscompares++;
        close_out();
    end
endmodule
